//--- core/ee_consts.vh
`ifndef EE_CONSTS_VH
`define EE_CONSTS_VH

// ----------------------------------------------------------------------
// Memory organisation
// ----------------------------------------------------------------------
`define EE_MEM_BYTES       4096
`define EE_ADDR_W          12
`define EE_PAGE_BYTES      32
`define EE_PAGE_W          5
`define EE_DATA_W          8

// ----------------------------------------------------------------------
// Slave-select byte fields
// ----------------------------------------------------------------------
`define EE_SEL_MAIN        4'ha
`define EE_SEL_ID          4'hb
`define EE_SEL_TYPE_HI     7
`define EE_SEL_TYPE_LO     4
`define EE_SEL_CHIP_HI     3
`define EE_SEL_CHIP_LO     1
`define EE_SEL_RW_BIT      0
`define EE_UNLOCKED_CHIP   3'h0

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define EE_CLK_PERIOD_NS   25
`define EE_T_PROG_MAX_NS   4000000
`define EE_PROG_CYCLES     (`EE_T_PROG_MAX_NS / `EE_CLK_PERIOD_NS)

// ----------------------------------------------------------------------
// Write buffer
// ----------------------------------------------------------------------
`define EE_FIFO_DEPTH      4
`define EE_FIFO_WIDTH      13

`endif

//--- core/ee_fifo.v
`timescale 1ns/1ps

module ee_fifo #(
  parameter WIDTH = 13,
  parameter DEPTH = 4
) (
  input  wire             clk_in,
  input  wire             rst_in,
  input  wire             en_in,
  input  wire             in_valid_in,
  output wire             in_ready_out,
  input  wire [WIDTH-1:0] in_data_in,
  output wire             out_valid_out,
  input  wire             out_ready_in,
  output wire [WIDTH-1:0] out_data_out
);

  reg [WIDTH-1:0] store_mem [0:DEPTH-1];
  reg [1:0]       wr_ptr_reg;
  reg [1:0]       rd_ptr_reg;
  reg [2:0]       count_reg;
  wire            push;
  wire            pop;

  assign in_ready_out  = (count_reg != DEPTH[2:0]);
  assign out_valid_out = (count_reg != 3'h0);
  assign out_data_out  = store_mem[rd_ptr_reg];
  assign push          = en_in & in_valid_in & in_ready_out;
  assign pop           = en_in & out_valid_out & out_ready_in;

  always @(posedge clk_in) begin
    if (push) begin
      store_mem[wr_ptr_reg] <= in_data_in;
    end
  end

  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      wr_ptr_reg <= 2'h0;
      rd_ptr_reg <= 2'h0;
      count_reg  <= 3'h0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 2'h1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 2'h1;
      end
      if (push & ~pop) begin
        count_reg <= count_reg + 3'h1;
      end else if (pop & ~push) begin
        count_reg <= count_reg - 3'h1;
      end
    end
  end

endmodule // ee_fifo

//--- core/ee_serial_store.v
// Summary of operation
// - Array of 4096 bytes, eight bits each, grouped in 32-byte pages.
// - Partial page writes program only the bytes actually received.
// - Programming is self-timed and ends within 4 ms.
// - Bus ignored during power-on reset; release resets state into standby.
// - Stop enters standby only once any programming cycle has finished.
// - Optional 32-byte identification page, lockable to read-only.
// - Write-protect high refuses all programming; low permits writes.
// - After device register unlock, write-protect is no longer honoured.
// - Unconnected strap inputs count as zero in address compare; here the straps have no pull-down and are compared as driven.
// - Three straps form low slave-address bits; up to eight devices share a bus.
// - After device register unlock, strap inputs are ignored.
// - Data line is only pulled low or released, never driven high.
// - Select byte acknowledged only for type 1010b or 1011b.
// - Select byte bit 0: one means read, zero means write.
// - No bus request is answered while programming runs.
`timescale 1ns/1ps
`include "ee_consts.vh"

module ee_serial_store #(
  parameter PROG_CYCLES  = `EE_PROG_CYCLES,
  parameter HAS_ID_PAGE  = 1
) (
  input  wire CLOCK_IN,
  input  wire RST_IN,
  input  wire CE_IN,
  input  wire SCL_IN,
  input  wire SDA_IN,
  output wire SDA_OUT,
  output wire SDA_OE_OUT,
  input  wire WP_IN,
  input  wire ADDR_STRAP_BIT0_IN,
  input  wire ADDR_STRAP_BIT1_IN,
  input  wire ADDR_STRAP_BIT2_IN,
  input  wire DEV_REG_UNLOCKED_IN,
  input  wire ID_LOCKED_IN,
  output wire BUSY_OUT,
  output wire STANDBY_OUT
);

  // ----------------------------------------------------------------------
  // States
  // ----------------------------------------------------------------------
  localparam [6:0] ST_IDLE   = 7'h01;
  localparam [6:0] ST_DEVSEL = 7'h02;
  localparam [6:0] ST_ADRH   = 7'h04;
  localparam [6:0] ST_ADRL   = 7'h08;
  localparam [6:0] ST_WDATA  = 7'h10;
  localparam [6:0] ST_RDATA  = 7'h20;
  localparam [6:0] ST_WAIT   = 7'h40;

  // ----------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------
  // Main array
  reg  [`EE_DATA_W-1:0] mem_array [0:`EE_MEM_BYTES-1];
  reg  [`EE_DATA_W-1:0] id_array  [0:`EE_PAGE_BYTES-1];
  reg  [`EE_DATA_W-1:0] page_buf  [0:`EE_PAGE_BYTES-1];

  reg  [6:0]              state_reg;
  reg                     scl_q_reg;
  reg                     sda_q_reg;
  reg  [3:0]              bit_cnt_reg;
  reg  [7:0]              shift_reg;
  reg  [7:0]              tx_reg;
  reg                     drive_low_reg;
  reg                     ack_reg;
  reg                     is_id_reg;
  reg                     rw_reg;
  reg                     master_ack_reg;
  reg  [`EE_ADDR_W-1:0]   addr_reg;
  reg  [`EE_ADDR_W-6:0]   page_base_reg;
  reg                     page_is_id_reg;
  reg  [`EE_PAGE_BYTES-1:0] mask_reg;
  reg                     prog_req_reg;
  reg                     busy_reg;
  reg                     commit_reg;
  reg  [31:0]             prog_cnt_reg;

  wire                    scl_rise;
  wire                    scl_fall;
  wire                    start_cond;
  wire                    stop_cond;
  wire [2:0]              strap_bits;
  wire                    wp_active;
  wire                    write_ok;
  wire                    fifo_in_ready;
  wire                    fifo_out_valid;
  wire                    fifo_out_ready;
  wire [`EE_FIFO_WIDTH-1:0] fifo_out_data;
  wire                    push_byte;
  wire [7:0]              rd_byte;
  reg                     sel_match;
  integer                 i;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // In-page wrap
  function [`EE_ADDR_W-1:0] page_wrap_inc;
    input [`EE_ADDR_W-1:0] a;
    begin
      page_wrap_inc = {a[`EE_ADDR_W-1:`EE_PAGE_W], a[`EE_PAGE_W-1:0] + 5'h01};
    end
  endfunction

  // ----------------------------------------------------------------------
  // Bus condition detection
  // ----------------------------------------------------------------------
  assign scl_rise   = ~scl_q_reg & SCL_IN;
  assign scl_fall   = scl_q_reg & ~SCL_IN;
  assign start_cond = scl_q_reg & SCL_IN & sda_q_reg & ~SDA_IN;
  assign stop_cond  = scl_q_reg & SCL_IN & ~sda_q_reg & SDA_IN;

  assign strap_bits = {ADDR_STRAP_BIT2_IN, ADDR_STRAP_BIT1_IN, ADDR_STRAP_BIT0_IN};

  assign wp_active = WP_IN & ~DEV_REG_UNLOCKED_IN;

  assign write_ok = ~wp_active & ~(is_id_reg & ID_LOCKED_IN);

  assign rd_byte = is_id_reg ? id_array[addr_reg[`EE_PAGE_W-1:0]] : mem_array[addr_reg];

  always @* begin
    sel_match = 1'b0;
    if (shift_reg[`EE_SEL_TYPE_HI:`EE_SEL_TYPE_LO] == `EE_SEL_MAIN) begin
      sel_match = 1'b1;
    end else if ((shift_reg[`EE_SEL_TYPE_HI:`EE_SEL_TYPE_LO] == `EE_SEL_ID) &&
                 (HAS_ID_PAGE != 0)) begin
      sel_match = 1'b1;
    end
    if (DEV_REG_UNLOCKED_IN) begin
      if (shift_reg[`EE_SEL_CHIP_HI:`EE_SEL_CHIP_LO] != `EE_UNLOCKED_CHIP) begin
        sel_match = 1'b0;
      end
    end else if (shift_reg[`EE_SEL_CHIP_HI:`EE_SEL_CHIP_LO] != strap_bits) begin
      sel_match = 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Data line
  // ----------------------------------------------------------------------
  // Open drain only
  assign SDA_OUT     = 1'b0;
  assign SDA_OE_OUT  = drive_low_reg;
  assign BUSY_OUT    = busy_reg | prog_req_reg;
  assign STANDBY_OUT = state_reg[0] & ~busy_reg & ~prog_req_reg;

  // ----------------------------------------------------------------------
  // Write buffer between receiver and page latch
  // ----------------------------------------------------------------------
  // Stalled by the page latch while programming; a full buffer turns into a NACK
  assign push_byte      = state_reg[4] & scl_fall & (bit_cnt_reg == 4'h8) &
                          write_ok & fifo_in_ready;
  assign fifo_out_ready = ~busy_reg;

  ee_fifo #(
    .WIDTH (`EE_FIFO_WIDTH),
    .DEPTH (`EE_FIFO_DEPTH)
  ) u_fifo (
    .clk_in        (CLOCK_IN),
    .rst_in        (RST_IN),
    .en_in         (CE_IN),
    .in_valid_in   (push_byte),
    .in_ready_out  (fifo_in_ready),
    .in_data_in    ({addr_reg[`EE_PAGE_W-1:0], shift_reg}),
    .out_valid_out (fifo_out_valid),
    .out_ready_in  (fifo_out_ready),
    .out_data_out  (fifo_out_data)
  );

  // ----------------------------------------------------------------------
  // Non-reset storage writes
  // ----------------------------------------------------------------------
  always @(posedge CLOCK_IN) begin
    if (CE_IN) begin
      if (fifo_out_valid & fifo_out_ready) begin
        page_buf[fifo_out_data[12:8]] <= fifo_out_data[7:0];
      end
      if (commit_reg) begin
        for (i = 0; i < `EE_PAGE_BYTES; i = i + 1) begin
          if (mask_reg[i]) begin
            if (page_is_id_reg) begin
              id_array[i] <= page_buf[i];
            end else begin
              mem_array[{page_base_reg, i[`EE_PAGE_W-1:0]}] <= page_buf[i];
            end
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Programming cycle
  // ----------------------------------------------------------------------
  always @(posedge CLOCK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      mask_reg     <= 32'h0000_0000;
      prog_req_reg <= 1'b0;
      busy_reg     <= 1'b0;
      commit_reg   <= 1'b0;
      prog_cnt_reg <= 32'h0000_0000;
    end else if (CE_IN) begin
      commit_reg <= 1'b0;
      if (state_reg[3] & scl_fall & (bit_cnt_reg == 4'h9)) begin
        mask_reg <= 32'h0000_0000;
      end else if (fifo_out_valid & fifo_out_ready) begin
        mask_reg[fifo_out_data[12:8]] <= 1'b1;
      end
      // Stop after written bytes launches programming
      if (stop_cond & state_reg[4] & (mask_reg != 32'h0000_0000 || fifo_out_valid)) begin
        prog_req_reg <= 1'b1;
      end else if (prog_req_reg & ~fifo_out_valid) begin
        prog_req_reg <= 1'b0;
        busy_reg     <= 1'b1;
        prog_cnt_reg <= PROG_CYCLES - 1;
      end else if (busy_reg) begin
        if (prog_cnt_reg == 32'h0000_0000) begin
          busy_reg   <= 1'b0;
          commit_reg <= 1'b1;
        end else begin
          prog_cnt_reg <= prog_cnt_reg - 32'h0000_0001;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Serial protocol engine
  // ----------------------------------------------------------------------
  // Reset returns to standby
  always @(posedge CLOCK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      state_reg      <= ST_IDLE;
      scl_q_reg      <= 1'b1;
      sda_q_reg      <= 1'b1;
      bit_cnt_reg    <= 4'h0;
      shift_reg      <= 8'h00;
      tx_reg         <= 8'h00;
      drive_low_reg  <= 1'b0;
      ack_reg        <= 1'b0;
      is_id_reg      <= 1'b0;
      rw_reg         <= 1'b0;
      master_ack_reg <= 1'b0;
      addr_reg       <= 12'h000;
      page_base_reg  <= 7'h00;
      page_is_id_reg <= 1'b0;
    end else if (CE_IN) begin
      scl_q_reg <= SCL_IN;
      sda_q_reg <= SDA_IN;
      if (start_cond) begin
        state_reg     <= ST_DEVSEL;
        bit_cnt_reg   <= 4'h0;
        drive_low_reg <= 1'b0;
      end else if (stop_cond) begin
        state_reg     <= ST_IDLE;
        bit_cnt_reg   <= 4'h0;
        drive_low_reg <= 1'b0;
      end else begin
        case (state_reg)
          ST_IDLE, ST_WAIT: begin
            drive_low_reg <= 1'b0;
          end
          ST_DEVSEL, ST_ADRH, ST_ADRL, ST_WDATA: begin
            if (scl_rise && bit_cnt_reg < 4'h8) begin
              shift_reg   <= {shift_reg[6:0], SDA_IN};
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end else if (scl_fall && bit_cnt_reg == 4'h8) begin
              bit_cnt_reg <= 4'h9;
              ack_reg     <= 1'b1;
              if (state_reg[1]) begin
                if (sel_match & ~busy_reg & ~prog_req_reg) begin
                  drive_low_reg <= 1'b1;
                  is_id_reg     <= shift_reg[`EE_SEL_TYPE_LO];
                  rw_reg        <= shift_reg[`EE_SEL_RW_BIT];
                end else begin
                  ack_reg <= 1'b0;
                end
              end else if (state_reg[2]) begin
                drive_low_reg          <= 1'b1;
                addr_reg[`EE_ADDR_W-1:8] <= shift_reg[3:0];
              end else if (state_reg[3]) begin
                drive_low_reg  <= 1'b1;
                addr_reg[7:0]  <= shift_reg;
                // Low address byte lands this same edge, so take its page bits directly
                page_base_reg  <= {addr_reg[`EE_ADDR_W-1:8], shift_reg[7:`EE_PAGE_W]};
                page_is_id_reg <= is_id_reg;
              end else if (push_byte) begin
                drive_low_reg <= 1'b1;
                addr_reg      <= page_wrap_inc(addr_reg);
              end else begin
                ack_reg <= 1'b0;
              end
            end else if (scl_fall && bit_cnt_reg == 4'h9) begin
              bit_cnt_reg   <= 4'h0;
              drive_low_reg <= 1'b0;
              if (!ack_reg) begin
                state_reg <= ST_WAIT;
              end else if (state_reg[1] & rw_reg) begin
                state_reg     <= ST_RDATA;
                tx_reg        <= {rd_byte[6:0], 1'b0};
                drive_low_reg <= ~rd_byte[7];
                bit_cnt_reg   <= 4'h1;
              end else if (state_reg[1]) begin
                state_reg <= ST_ADRH;
              end else if (state_reg[2]) begin
                state_reg <= ST_ADRL;
              end else begin
                state_reg <= ST_WDATA;
              end
            end
          end
          ST_RDATA: begin
            if (scl_fall && bit_cnt_reg < 4'h8) begin
              drive_low_reg <= ~tx_reg[7];
              tx_reg        <= {tx_reg[6:0], 1'b0};
              bit_cnt_reg   <= bit_cnt_reg + 4'h1;
            end else if (scl_fall && bit_cnt_reg == 4'h8) begin
              drive_low_reg <= 1'b0;
              bit_cnt_reg   <= 4'h9;
              // Sequential read walks the whole main array, not just the page; the ID page wraps within itself
              if (is_id_reg) begin
                addr_reg <= page_wrap_inc(addr_reg);
              end else begin
                addr_reg <= addr_reg + 12'h001;
              end
            end else if (scl_rise && bit_cnt_reg == 4'h9) begin
              master_ack_reg <= ~SDA_IN;
            end else if (scl_fall && bit_cnt_reg == 4'h9) begin
              if (master_ack_reg) begin
                tx_reg        <= {rd_byte[6:0], 1'b0};
                drive_low_reg <= ~rd_byte[7];
                bit_cnt_reg   <= 4'h1;
              end else begin
                state_reg   <= ST_WAIT;
                bit_cnt_reg <= 4'h0;
              end
            end
          end
          default: begin
            state_reg     <= ST_IDLE;
            drive_low_reg <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule // ee_serial_store

//--- tb/ee_bus_master.sv
`timescale 1ns/1ps
// ----
// Bus master model
// ----
module ee_bus_master (
  input  wire clk_in,
  input  wire oe_in,
  output reg  scl_out,
  output wire sda_out
);
  reg sda_drv_reg;
  assign sda_out = sda_drv_reg & ~oe_in;
  initial begin
    scl_out = 1'b1;
    sda_drv_reg = 1'b1;
  end
  // Two clocks keep SDA changes clear of SCL edges
  task hb;
    repeat (2) @(negedge clk_in);
  endtask
  task start;
    sda_drv_reg = 1'b1;
    hb;
    scl_out = 1'b1;
    hb;
    sda_drv_reg = 1'b0;
    hb;
    scl_out = 1'b0;
    hb;
  endtask
  task stop;
    sda_drv_reg = 1'b0;
    hb;
    scl_out = 1'b1;
    hb;
    sda_drv_reg = 1'b1;
    hb;
  endtask
  task bit_x(input logic b, output logic r);
    sda_drv_reg = b;
    hb;
    scl_out = 1'b1;
    hb;
    r = sda_out;
    hb;
    scl_out = 1'b0;
    hb;
  endtask
  task wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], r);
    end
    bit_x(1'b1, r);
    ack = (r === 1'b0);
  endtask
  task rbyte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, d[i]);
    end
    bit_x(last, r);
  endtask
endmodule // ee_bus_master

//--- tb/ee_serial_store_monitor.sv
`timescale 1ns/1ps
module ee_serial_store_monitor #(
  parameter PROG_CYCLES = 160000,
  parameter HAS_ID_PAGE = 1
) (
  input wire CLOCK_IN,
  input wire RST_IN,
  input wire CE_IN,
  input wire SCL_IN,
  input wire SDA_IN,
  input wire SDA_OUT,
  input wire SDA_OE_OUT,
  input wire WP_IN,
  input wire ADDR_STRAP_BIT0_IN,
  input wire ADDR_STRAP_BIT1_IN,
  input wire ADDR_STRAP_BIT2_IN,
  input wire DEV_REG_UNLOCKED_IN,
  input wire ID_LOCKED_IN,
  input wire BUSY_OUT,
  input wire STANDBY_OUT
);
  // Margin covers the write buffer draining before the timer starts
  localparam int BUSY_MAX = PROG_CYCLES + 16;
  int busy_cnt;
  always @(posedge CLOCK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      busy_cnt <= 0;
    end else begin
      busy_cnt <= BUSY_OUT ? busy_cnt + 1 : 0;
    end
  end
  default clocking cb @(posedge CLOCK_IN);
  endclocking
  default disable iff (RST_IN);
  sequence prog_end;
    $fell(BUSY_OUT);
  endsequence
  sequence stop_seen;
    SCL_IN && !SDA_IN ##1 SCL_IN && SDA_IN;
  endsequence
  a_sda_low_only: assert property (SDA_OUT == 1'b0)
    else $error("data line driven high");
  a_oe_scl_low: assert property ($changed(SDA_OE_OUT) |-> !SCL_IN)
    else $error("data line moved while clock high");
  a_reset_idle: assert property ($fell(RST_IN) |-> STANDBY_OUT && !BUSY_OUT && !SDA_OE_OUT)
    else $error("not idle after reset");
  a_standby_idle: assert property (STANDBY_OUT |-> !BUSY_OUT)
    else $error("standby while programming");
  a_busy_silent: assert property (BUSY_OUT |-> !SDA_OE_OUT)
    else $error("answer while programming");
  a_prog_long: assert property (prog_end |-> busy_cnt >= PROG_CYCLES)
    else $error("programming too short");
  a_prog_bound: assert property ($rose(BUSY_OUT) |-> ##[1:BUSY_MAX] !BUSY_OUT)
    else $error("programming too long");
  a_wp_no_prog: assert property ($rose(BUSY_OUT) |-> !WP_IN || DEV_REG_UNLOCKED_IN)
    else $error("programming under write protect");
  a_standby_after: assert property (prog_end |-> ##[0:2] STANDBY_OUT)
    else $error("no standby after programming");
  a_stop_standby: assert property (stop_seen ##1 !BUSY_OUT [*4] |-> STANDBY_OUT)
    else $error("no standby after stop");
endmodule // ee_serial_store_monitor

bind ee_serial_store ee_serial_store_monitor #(.PROG_CYCLES(PROG_CYCLES),
  .HAS_ID_PAGE(HAS_ID_PAGE)) mon_u (.CLOCK_IN(CLOCK_IN), .RST_IN(RST_IN), .CE_IN(CE_IN),
  .SCL_IN(SCL_IN), .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT), .SDA_OE_OUT(SDA_OE_OUT), .WP_IN(WP_IN),
  .ADDR_STRAP_BIT0_IN(ADDR_STRAP_BIT0_IN), .ADDR_STRAP_BIT1_IN(ADDR_STRAP_BIT1_IN),
  .ADDR_STRAP_BIT2_IN(ADDR_STRAP_BIT2_IN), .DEV_REG_UNLOCKED_IN(DEV_REG_UNLOCKED_IN),
  .ID_LOCKED_IN(ID_LOCKED_IN), .BUSY_OUT(BUSY_OUT), .STANDBY_OUT(STANDBY_OUT));

//--- tb/i2c_serial_eeprom_32kbit_tb_top.sv
`timescale 1ns/1ps
module i2c_serial_eeprom_32kbit_tb_top;
  // Long enough that a busy poll fits inside one cycle
  localparam int PROG = 200;
  localparam int LIMIT = 30000;
  logic       clk, rst, wp, unlocked, id_locked;
  logic [2:0] strap;
  wire        scl, sda, oe, busy, standby;
  int         error_cnt, checked, cyc_cnt;

  ee_serial_store #(.PROG_CYCLES(PROG), .HAS_ID_PAGE(1)) dut_u (.CLOCK_IN(clk), .RST_IN(rst),
    .CE_IN(1'b1), .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(), .SDA_OE_OUT(oe), .WP_IN(wp),
    .ADDR_STRAP_BIT0_IN(strap[0]), .ADDR_STRAP_BIT1_IN(strap[1]), .ADDR_STRAP_BIT2_IN(strap[2]),
    .DEV_REG_UNLOCKED_IN(unlocked), .ID_LOCKED_IN(id_locked), .BUSY_OUT(busy),
    .STANDBY_OUT(standby));
  ee_bus_master bm_u (.clk_in(clk), .oe_in(oe), .scl_out(scl), .sda_out(sda));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == LIMIT) begin
      error_cnt++;
      end_sim;
    end
  end
  // ----
  // Checks
  // ----
  task chk_bit(input string name, input logic exp, input logic got);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s exp %b got %b", name, exp, got);
    end
  endtask
  task chk_byte(input string name, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", name, exp, got);
    end
  endtask
  task end_sim;
    $display("checked %0d error_cnt %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // ----
  // Transfers
  // ----
  task sel_addr(input logic [7:0] sel, input logic [11:0] a);
    logic k;
    bm_u.start;
    bm_u.wbyte(sel, k);
    chk_bit("select ack", 1'b1, k);
    bm_u.wbyte({4'h0, a[11:8]}, k);
    chk_bit("addr ack", 1'b1, k);
    bm_u.wbyte(a[7:0], k);
    chk_bit("addr ack", 1'b1, k);
  endtask
  task wr(input logic [7:0] sel, input logic [11:0] a, input logic [7:0] d, input int n,
          input logic ok);
    logic k;
    sel_addr(sel, a);
    for (int i = 0; i < n; i++) begin
      bm_u.wbyte(d + i[7:0], k);
      chk_bit("data ack", ok, k);
    end
    bm_u.stop;
  endtask
  task rd(input logic [7:0] sel, input logic [11:0] a, input logic [7:0] exp);
    logic       k;
    logic [7:0] d;
    sel_addr(sel, a);
    bm_u.start;
    // bit zero set asks for a read
    bm_u.wbyte(sel | 8'h01, k);
    chk_bit("read select ack", 1'b1, k);
    bm_u.rbyte(1'b1, d);
    bm_u.stop;
    chk_byte("read data", exp, d);
  endtask
  task wait_idle;
    int n;
    n = 0;
    while (busy !== 1'b0 && n < PROG + 40) begin
      @(negedge clk);
      n++;
    end
    chk_bit("busy end", 1'b0, busy);
    repeat (2) @(negedge clk);
    chk_bit("standby", 1'b1, standby);
  endtask
  // ----
  // Scenarios
  // ----
  task t_reset;
    chk_bit("standby", 1'b1, standby);
    chk_bit("busy", 1'b0, busy);
    chk_bit("sda pull", 1'b0, oe);
  endtask
  task t_write_busy;
    logic k;
    wr(8'ha0, 12'h123, 8'h5a, 1, 1'b1);
    chk_bit("busy", 1'b1, busy);
    bm_u.start;
    bm_u.wbyte(8'ha0, k);
    bm_u.stop;
    chk_bit("busy poll ack", 1'b0, k);
    chk_bit("standby", 1'b0, standby);
    wait_idle;
    rd(8'ha0, 12'h123, 8'h5a);
  endtask
  task t_page;
    wr(8'ha0, 12'hffd, 8'h3c, 1, 1'b1);
    wait_idle;
    wr(8'ha0, 12'hffe, 8'hc1, 3, 1'b1);
    wait_idle;
    rd(8'ha0, 12'hffe, 8'hc1);
    rd(8'ha0, 12'hfff, 8'hc2);
    rd(8'ha0, 12'hfe0, 8'hc3);
    rd(8'ha0, 12'hffd, 8'h3c);
  endtask
  task t_select;
    logic [47:0] sels;
    logic [5:0]  acks;
    logic        k;
    sels = 48'h9aaaa0baa0aa;
    acks = 6'b010110;
    strap = 3'h5;
    for (int i = 0; i < 6; i++) begin
      unlocked = (i > 3);
      bm_u.start;
      bm_u.wbyte(sels[47 - 8 * i -: 8], k);
      bm_u.stop;
      chk_bit("select ack", acks[5 - i], k);
    end
    unlocked = 1'b0;
    strap = 3'h0;
  endtask
  task t_protect;
    wr(8'ha0, 12'h040, 8'h11, 1, 1'b1);
    wait_idle;
    wp = 1'b1;
    wr(8'ha0, 12'h040, 8'h22, 1, 1'b0);
    repeat (4) @(negedge clk);
    chk_bit("busy", 1'b0, busy);
    rd(8'ha0, 12'h040, 8'h11);
    unlocked = 1'b1;
    wr(8'ha0, 12'h040, 8'h33, 1, 1'b1);
    wait_idle;
    rd(8'ha0, 12'h040, 8'h33);
    unlocked = 1'b0;
    wp = 1'b0;
  endtask
  task t_id;
    wr(8'hb0, 12'h005, 8'h77, 1, 1'b1);
    wait_idle;
    id_locked = 1'b1;
    wr(8'hb0, 12'h005, 8'h88, 1, 1'b0);
    rd(8'hb0, 12'h005, 8'h77);
    id_locked = 1'b0;
  endtask

  initial begin
    rst = 1'b1;
    wp = 1'b0;
    unlocked = 1'b0;
    id_locked = 1'b0;
    strap = 3'h0;
    error_cnt = 0;
    checked = 0;
    cyc_cnt = 0;
    repeat (8) @(negedge clk);
    rst = 1'b0;
    repeat (2) @(negedge clk);
    t_reset;
    t_write_busy;
    t_page;
    t_select;
    t_protect;
    t_id;
    end_sim;
  end
endmodule // i2c_serial_eeprom_32kbit_tb_top
